// >>> src/rotor_position_detector_consts.svh
`ifndef ROTOR_POSITION_DETECTOR_CONSTS_SVH
`define ROTOR_POSITION_DETECTOR_CONSTS_SVH

// Register indices on the bus (byte address is four times the index).
`define RPD_IDX_CONTROL      2'h0
`define RPD_IDX_CONFIG       2'h1
`define RPD_IDX_STATUS       2'h2
`define RPD_IDX_DELAY        2'h3

// Control register fields.
`define RPD_CTL_STOP         7
`define RPD_CTL_START        6
`define RPD_CTL_TSTOP_EN     5
`define RPD_CTL_TSTART_EN    4
`define RPD_CTL_PINSEL       3
`define RPD_CTL_RECOUNT      2
`define RPD_CTL_MODE         1
`define RPD_CTL_ENABLE       0

// Configuration register fields.
`define RPD_CFG_CLK_HI       7
`define RPD_CFG_CLK_LO       6
`define RPD_CFG_WIN_HI       5
`define RPD_CFG_WIN_LO       4
`define RPD_CFG_CNT_HI       3
`define RPD_CFG_CNT_LO       0

// Status register fields.
`define RPD_STS_EDGE_HI      5
`define RPD_STS_EDGE_LO      4
`define RPD_STS_ACTIVE       3

// Reset values.
`define RPD_RST_CONTROL      8'h00
`define RPD_RST_CONFIG       8'h00
`define RPD_RST_DELAY        7'h00

// Sampling window encodings.
`define RPD_WIN_PWM_ON       2'h0
`define RPD_WIN_CONTINUOUS   2'h1
`define RPD_WIN_LOW_SIDE     2'h2

// Timing: one delay step is 8 clocks, 400 ns at 20 MHz.
`define RPD_CLOCK_HZ         20000000
`define RPD_DELAY_STEP_NS    400
`define RPD_DELAY_STEP_CYC   ((`RPD_DELAY_STEP_NS * (`RPD_CLOCK_HZ / 1000000) + 999) / 1000)
`define RPD_PRESCALE_MIN_LOG 2

`endif

// >>> src/rotor_position_detector_pkg.sv
package rotor_position_detector_pkg;

  typedef struct packed {
    logic [2:0] w_v_u;
  } phase_bits_t;

  typedef struct packed {
    logic [1:0] sample_clock_select;
    logic [1:0] sampling_window_select;
    logic [3:0] match_count_threshold;
  } sample_config_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_SAMPLING = 2'b01,
    ST_STOPPING = 2'b10
  } detect_state_t;

endpackage

// >>> src/rotor_position_detector.sv
`timescale 1ns/1ps
`include "rotor_position_detector_consts.svh"

// What this block does
// (RULE1) Hold two-bit PWM edge detection result
// (RULE2) Falling edge sets upper, rising sets lower
// (RULE3) Active flag shows sampling in progress
// (RULE4) Snapshot inputs at start, W V U
// (RULE5) Sample period is clock over 4..32
// (RULE6) Window: PWM on, continuous, low-side
// (RULE7) Ordinary mode needs N consecutive matches
// (RULE8) Change mode needs N consecutive differences
// (RULE9) Software stop bit requests stop
// (RULE10) After stop, sample until match, then halt
// (RULE11) Software start bit begins sampling
// (RULE12) Timer stop trigger requests stop when enabled
// (RULE13) Timer start trigger begins sampling when enabled
// (RULE14) Pin select: three pins or U only
// (RULE15) Unused pins are driven as zero externally
// (RULE16) Recount resets match counter at PWM off
// (RULE17) Ordinary mode detects mismatch then match
// (RULE18) Change mode detects change from snapshot
// (RULE19) Enable bit activates the detector
// (RULE20) Delay suppresses sampling after PWM on
// (RULE21) Delay step is eight clocks each
// (RULE22) Count values 0 and 1 mean one
// (RULE23) Reconfigure only while detector disabled
// (RULE24) Window codes 00,01,10; 11 reserved
// (RULE25) One-clock interrupt pulse per detection
module rotor_position_detector #(
  parameter int DELAY_WIDTH = 7,
  parameter int COUNT_WIDTH = 4
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_phase_u_sense,
  input  wire logic        i_phase_v_sense,
  input  wire logic        i_phase_w_sense,
  input  wire logic [2:0]  i_expected_wvu,
  input  wire logic        i_pwm_on,
  input  wire logic [2:0]  i_low_side_on,
  input  wire logic        i_start_timer_trigger,
  input  wire logic        i_stop_timer_trigger,
  output logic             o_detect_irq,
  output logic             o_sampling_active
);

  generate
    if (DELAY_WIDTH != 7 || COUNT_WIDTH != 4) begin : g_bad_widths
      $error("rotor_position_detector supports only the documented field widths");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------------

  // Three stages; the value counts once stages two and three agree.
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] phase_ff;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
    end else begin
      sync1_ff <= {i_phase_w_sense, i_phase_v_sense, i_phase_u_sense};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase_filter
      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          phase_ff[g] <= 1'b0;
        end else if (sync2_ff[g] == sync3_ff[g]) begin
          phase_ff[g] <= sync3_ff[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  logic [7:0]                             control_ff;
  rotor_position_detector_pkg::sample_config_t config_ff;
  logic [DELAY_WIDTH-1:0]                 delay_ff;
  rotor_position_detector_pkg::phase_bits_t snapshot_ff;
  logic [1:0]                             edge_result_ff;
  rotor_position_detector_pkg::detect_state_t state_ff;
  logic                                   sw_start_ff;
  logic                                   sw_stop_ff;

  logic       bus_req;
  logic       bus_write;
  logic [1:0] bus_idx;
  logic       lane0_write;

  assign bus_req     = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign bus_write   = bus_req && i_wb_we;
  assign bus_idx     = i_wb_adr[3:2];
  assign lane0_write = bus_write && i_wb_sel[0];

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= bus_req;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (bus_req && !i_wb_we) begin
      unique case (bus_idx)
        `RPD_IDX_CONTROL: o_wb_dat <= {24'h00_0000, 2'h0, control_ff[5:0]};
        `RPD_IDX_CONFIG:  o_wb_dat <= {24'h00_0000, config_ff};
        `RPD_IDX_STATUS:  o_wb_dat <= {24'h00_0000, 2'h0, edge_result_ff, o_sampling_active,
                                       snapshot_ff.w_v_u}; // see (RULE1) see (RULE3) see (RULE4)
        `RPD_IDX_DELAY:   o_wb_dat <= {24'h00_0000, 1'h0, delay_ff};
      endcase
    end
  end

  // Control: bits 7 and 6 are write-only strobes and never stored.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      control_ff <= `RPD_RST_CONTROL;
    end else if (lane0_write && bus_idx == `RPD_IDX_CONTROL) begin
      control_ff <= {2'h0, i_wb_dat[5:0]};
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sw_start_ff <= 1'b0;
      sw_stop_ff  <= 1'b0;
    end else begin
      sw_start_ff <= lane0_write && bus_idx == `RPD_IDX_CONTROL && i_wb_dat[`RPD_CTL_START]; // see (RULE11)
      sw_stop_ff  <= lane0_write && bus_idx == `RPD_IDX_CONTROL && i_wb_dat[`RPD_CTL_STOP];  // see (RULE9)
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      config_ff <= `RPD_RST_CONFIG;
    end else if (lane0_write && bus_idx == `RPD_IDX_CONFIG) begin
      config_ff <= i_wb_dat[7:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      delay_ff <= `RPD_RST_DELAY;
    end else if (lane0_write && bus_idx == `RPD_IDX_DELAY) begin
      delay_ff <= i_wb_dat[DELAY_WIDTH-1:0];
    end
  end

  logic enabled;
  assign enabled = control_ff[`RPD_CTL_ENABLE]; // see (RULE19)

  // ----------------------------------------------------------------------
  // Sample clock prescaler
  // ----------------------------------------------------------------------

  logic [4:0] prescale_ff;
  logic       sample_tick;
  logic [4:0] prescale_last;

  // Period is 4 << select clocks, so terminal count is that minus one.
  assign prescale_last = 5'((5'h1 << (`RPD_PRESCALE_MIN_LOG + config_ff.sample_clock_select)) - 5'h1); // see (RULE5)
  assign sample_tick   = (prescale_ff == prescale_last);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      prescale_ff <= 5'h00;
    end else if (!enabled || sample_tick) begin
      prescale_ff <= 5'h00;
    end else begin
      prescale_ff <= prescale_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Sampling window and delay after turn-on
  // ----------------------------------------------------------------------

  localparam int STEP_CYC = `RPD_DELAY_STEP_CYC;
  localparam int DLY_CW   = DELAY_WIDTH + 4;

  logic              pwm_ff;
  logic              pwm_rise;
  logic              pwm_fall;
  logic              low_any;
  logic              low_any_ff;
  logic              gate_on;
  logic              gate_rise;
  logic [DLY_CW-1:0] delay_cnt_ff;
  logic [DLY_CW-1:0] delay_total;
  logic              window_open;

  assign low_any     = |i_low_side_on;
  assign pwm_rise    = i_pwm_on && !pwm_ff;
  assign pwm_fall    = !i_pwm_on && pwm_ff;
  assign gate_on     = (config_ff.sampling_window_select == `RPD_WIN_LOW_SIDE) ? low_any : i_pwm_on;
  assign gate_rise   = (config_ff.sampling_window_select == `RPD_WIN_LOW_SIDE) ? (low_any && !low_any_ff) : pwm_rise;
  assign delay_total = DLY_CW'(delay_ff) * DLY_CW'(STEP_CYC); // see (RULE21)

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pwm_ff     <= 1'b0;
      low_any_ff <= 1'b0;
    end else begin
      pwm_ff     <= i_pwm_on;
      low_any_ff <= low_any;
    end
  end

  // Counts clocks since the window's turn-on; sampling waits for the delay except in the continuous window.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      delay_cnt_ff <= '0;
    end else if (gate_rise || !gate_on) begin
      delay_cnt_ff <= '0;
    end else if (delay_cnt_ff < delay_total) begin
      delay_cnt_ff <= delay_cnt_ff + DLY_CW'(1); // see (RULE20)
    end
  end

  always_comb begin
    unique case (config_ff.sampling_window_select)
      `RPD_WIN_PWM_ON:     window_open = i_pwm_on && !pwm_rise && delay_cnt_ff >= delay_total; // see (RULE6)
      `RPD_WIN_CONTINUOUS: window_open = 1'b1;
      `RPD_WIN_LOW_SIDE:   window_open = low_any && !gate_rise && delay_cnt_ff >= delay_total;
      default:             window_open = 1'b0; // see (RULE24)
    endcase
  end

  // ----------------------------------------------------------------------
  // Comparison and match counting
  // ----------------------------------------------------------------------

  logic [2:0]             cmp_mask;
  logic [2:0]             reference;
  logic                   inputs_equal;
  logic                   hit;
  logic                   sample_now;
  logic [COUNT_WIDTH-1:0] match_cnt_ff;
  logic [COUNT_WIDTH-1:0] threshold;
  logic                   qualified;
  logic                   recount_clear;
  logic                   sampling;
  logic                   start_req;
  logic                   stop_req;

  assign cmp_mask      = control_ff[`RPD_CTL_PINSEL] ? 3'h1 : 3'h7; // see (RULE14)
  assign reference     = control_ff[`RPD_CTL_MODE] ? snapshot_ff.w_v_u : i_expected_wvu;
  assign inputs_equal  = ((phase_ff ^ reference) & cmp_mask) == 3'h0;
  assign hit           = control_ff[`RPD_CTL_MODE] ? !inputs_equal : inputs_equal; // see (RULE17) see (RULE18)
  assign sampling      = (state_ff != rotor_position_detector_pkg::ST_IDLE);
  assign sample_now    = sampling && sample_tick && window_open;
  assign threshold     = (config_ff.match_count_threshold == 4'h0) ? 4'h1 : config_ff.match_count_threshold; // see (RULE22)
  assign qualified     = sample_now && hit && (match_cnt_ff + 4'h1 >= threshold); // see (RULE7) see (RULE8)
  assign recount_clear = control_ff[`RPD_CTL_RECOUNT] &&
                         config_ff.sampling_window_select == `RPD_WIN_PWM_ON && pwm_fall; // see (RULE16)
  assign start_req     = enabled && (sw_start_ff ||
                         (control_ff[`RPD_CTL_TSTART_EN] && i_start_timer_trigger)); // see (RULE11) see (RULE13)
  assign stop_req      = sw_stop_ff ||
                         (control_ff[`RPD_CTL_TSTOP_EN] && i_stop_timer_trigger); // see (RULE9) see (RULE12)

  // A miss breaks the run of consecutive hits.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      match_cnt_ff <= 4'h0;
    end else if (!sampling || recount_clear || qualified) begin
      match_cnt_ff <= 4'h0;
    end else if (sample_now) begin
      match_cnt_ff <= hit ? match_cnt_ff + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Sampling state machine
  // ----------------------------------------------------------------------

  rotor_position_detector_pkg::detect_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rotor_position_detector_pkg::ST_IDLE: begin
        if (start_req) begin
          nxt_state = rotor_position_detector_pkg::ST_SAMPLING;
        end
      end
      rotor_position_detector_pkg::ST_SAMPLING: begin
        if (qualified) begin
          nxt_state = rotor_position_detector_pkg::ST_IDLE; // see (RULE25)
        end else if (stop_req) begin
          nxt_state = rotor_position_detector_pkg::ST_STOPPING;
        end
      end
      rotor_position_detector_pkg::ST_STOPPING: begin
        if (qualified) begin
          nxt_state = rotor_position_detector_pkg::ST_IDLE; // see (RULE10)
        end
      end
      default: nxt_state = rotor_position_detector_pkg::ST_IDLE;
    endcase
    if (!enabled) begin
      nxt_state = rotor_position_detector_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= rotor_position_detector_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sampling_active <= 1'b0;
      o_detect_irq      <= 1'b0;
    end else begin
      o_sampling_active <= (nxt_state != rotor_position_detector_pkg::ST_IDLE); // see (RULE3)
      o_detect_irq      <= qualified && enabled; // see (RULE25)
    end
  end

  // Snapshot of the inputs taken as sampling starts.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      snapshot_ff <= 3'h0;
    end else if (!sampling && start_req) begin
      snapshot_ff <= phase_ff & cmp_mask; // see (RULE4)
    end
  end

  // ----------------------------------------------------------------------
  // Edge result capture
  // ----------------------------------------------------------------------

  // Detection seen at the PWM falling edge sets bit 1, at the rising edge bit 0.
  logic detected_ff;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      detected_ff <= 1'b0;
    end else if (!sampling && start_req) begin
      detected_ff <= 1'b0;
    end else if (qualified) begin
      detected_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_result_ff <= 2'h0;
    end else if (!sampling && start_req) begin
      edge_result_ff <= 2'h0;
    end else begin
      if (pwm_fall) begin
        edge_result_ff[1] <= detected_ff || qualified; // see (RULE1) see (RULE2)
      end
      if (pwm_rise) begin
        edge_result_ff[0] <= detected_ff || qualified; // see (RULE2)
      end
    end
  end

endmodule

// >>> dv/rotor_position_detector_asserts.sv
`timescale 1ns/1ps
module rotor_position_detector_asserts (
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [3:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        o_detect_irq,
  input wire logic        o_sampling_active
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  sequence take_s;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence ctl_wr_s;
    take_s ##0 (i_wb_we && i_wb_sel[0] && i_wb_adr[3:2] == 2'h0);
  endsequence
  ack_timing_a: assert property (take_s |=> o_wb_ack)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  read_active_a: assert property (
    take_s ##0 (!i_wb_we && i_wb_adr[3:2] == 2'h2) |=> o_wb_dat[3] == $past(o_sampling_active))
    else $error("status active bit differs from sampling flag");
  strobe_read_a: assert property (
    take_s ##0 (!i_wb_we && i_wb_adr[3:2] == 2'h0) |=> o_wb_dat[7:6] == 2'h0)
    else $error("start or stop bit reads back nonzero");
  start_active_a: assert property (
    ctl_wr_s ##0 (i_wb_dat[6] && i_wb_dat[0] && !i_wb_dat[7]) |-> ##[1:4] o_sampling_active)
    else $error("software start did not begin sampling");
  disable_idle_a: assert property (ctl_wr_s ##0 !i_wb_dat[0] |-> ##[1:3] !o_sampling_active)
    else $error("disable did not stop sampling");
  irq_pulse_a: assert property (o_detect_irq |=> !o_detect_irq)
    else $error("interrupt longer than one cycle");
  irq_halts_a: assert property (o_detect_irq |-> ##[0:2] !o_sampling_active)
    else $error("sampling continued after detection");
  irq_cause_a: assert property ($rose(o_detect_irq) |-> $past(o_sampling_active))
    else $error("interrupt without sampling");
endmodule

bind rotor_position_detector rotor_position_detector_asserts chk_u (.i_clock, .i_resetn, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_detect_irq, .o_sampling_active);

// >>> dv/rpd_phase_model.sv
`timescale 1ns/1ps
module rpd_phase_model (
  input  wire logic       i_clock,
  input  wire logic [2:0] i_wvu,
  input  wire logic [2:0] i_keep,
  input  wire logic       i_slow,
  output logic            o_u,
  output logic            o_v,
  output logic            o_w
);
  logic [2:0] lag_ff;
  logic [2:0] lag2_ff;
  // Pins not kept are set as outputs by software and read as zero.
  always_ff @(posedge i_clock) begin
    lag_ff  <= i_wvu & i_keep;
    lag2_ff <= lag_ff;
  end
  assign {o_w, o_v, o_u} = i_slow ? lag2_ff : (i_wvu & i_keep);
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "rotor_position_detector_consts.svh"
module tb_top;
  localparam logic [3:0] a_ctl = {`RPD_IDX_CONTROL, 2'b00};
  localparam logic [3:0] a_cfg = {`RPD_IDX_CONFIG, 2'b00};
  localparam logic [3:0] a_sts = {`RPD_IDX_STATUS, 2'b00};
  localparam logic [3:0] a_dly = {`RPD_IDX_DELAY, 2'b00};
  logic        clock, resetn, cyc, stb, we, ack, irq, active, pwm_on, tstart, tstop, slow, u, v, w;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat;
  logic [2:0]  wvu, expect_wvu, low_side;
  int          mismatches, comparisons, ticks;

  rotor_position_detector dut_u (.i_clock(clock), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_phase_u_sense(u), .i_phase_v_sense(v), .i_phase_w_sense(w), .i_expected_wvu(expect_wvu),
    .i_pwm_on(pwm_on), .i_low_side_on(low_side), .i_start_timer_trigger(tstart),
    .i_stop_timer_trigger(tstop), .o_detect_irq(irq), .o_sampling_active(active));
  rpd_phase_model far_u (.i_clock(clock), .i_wvu(wvu), .i_keep(3'h7), .i_slow(slow), .o_u(u), .o_v(v),
    .o_w(w));

  // ----------------------------------------
  // Bus and compare helpers.
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) chk("wb_ack", 1, 0);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(name, exp, q);
  endtask

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask

  task automatic pulse(input logic stop);
    if (stop) tstop <= 1'b1;
    else tstart <= 1'b1;
    @(posedge clock);
    tstop <= 1'b0;
    tstart <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // Settings change only while the detector is disabled.
  task automatic detect(input logic [7:0] cfg, input logic [7:0] ctl, input logic [2:0] pre,
                        input logic [2:0] post, input int lim, output int n);
    wvu <= pre;
    wr(a_ctl, 8'h00);
    wr(a_cfg, cfg);
    wr(a_ctl, ctl);
    wr(a_ctl, ctl | 8'h40);
    repeat (6) @(posedge clock);
    wvu <= post;
    wait_irq(lim, n);
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_regs();
    rd_chk("ctl_rst", a_ctl, `RPD_RST_CONTROL);
    rd_chk("cfg_rst", a_cfg, `RPD_RST_CONFIG);
    rd_chk("sts_rst", a_sts, 8'h00);
    rd_chk("dly_rst", a_dly, {1'b0, `RPD_RST_DELAY});
    wr(a_cfg, 8'hc6);
    rd_chk("cfg_rw", a_cfg, 8'hc6);
    wr(a_dly, 8'hff);
    rd_chk("dly_rw", a_dly, 8'h7f);
    wr(a_sts, 8'hff);
    rd_chk("sts_ro", a_sts, 8'h00);
    wr(a_ctl, 8'hfe);
    rd_chk("ctl_rw", a_ctl, 8'h3e);
    chk("start_disabled", 0, active);
    wr(a_ctl, 8'h00);
    wr(a_dly, 8'h00);
  endtask

  task automatic t_counts();
    int n;
    for (int s = 0; s < 4; s++) begin
      detect({s[1:0], 6'h13}, 8'h01, 3'b010, 3'b101, 2000, n);
      chk("latency", 1, n >= 2 * (4 << s) && n <= 3 * (4 << s) + 10);
      chk("halted", 0, active);
    end
    for (int c = 0; c < 2; c++) begin
      detect(8'h10 | 8'(c), 8'h01, 3'b010, 3'b101, 100, n);
      chk("single", 1, n <= 14);
    end
  endtask

  task automatic t_change();
    int n;
    slow <= 1'b1;
    wvu <= 3'b010;
    wr(a_ctl, 8'h00);
    wr(a_cfg, 8'h11);
    wr(a_ctl, 8'h43);
    repeat (4) @(posedge clock);
    rd_chk("snapshot", a_sts, 8'h0a);
    wait_irq(20, n);
    chk("steady", 20, n);
    wvu <= 3'b011;
    wait_irq(100, n);
    chk("changed", 1, n < 100);
    slow <= 1'b0;
  endtask

  task automatic t_pins();
    int n;
    expect_wvu <= 3'b001;
    detect(8'h11, 8'h09, 3'b110, 3'b111, 100, n);
    chk("u_only", 1, n < 100);
    detect(8'h11, 8'h01, 3'b110, 3'b111, 100, n);
    chk("three_pin", 100, n);
    expect_wvu <= 3'b101;
  endtask

  task automatic t_stop();
    int n;
    wvu <= 3'b010;
    wr(a_ctl, 8'h00);
    wr(a_cfg, 8'h11);
    wr(a_ctl, 8'h01);
    pulse(1'b0);
    chk("tstart_off", 0, active);
    wr(a_ctl, 8'h31);
    pulse(1'b0);
    chk("tstart_on", 1, active);
    pulse(1'b1);
    wait_irq(30, n);
    chk("tstop_waits", 1, active);
    wvu <= 3'b101;
    wait_irq(100, n);
    chk("tstop_match", 1, n < 100);
    wvu <= 3'b010;
    repeat (6) @(posedge clock);
    wr(a_ctl, 8'h41);
    wr(a_ctl, 8'h81);
    wait_irq(30, n);
    chk("swstop_waits", 1, active);
    wvu <= 3'b101;
    wait_irq(100, n);
    chk("swstop_match", 1, n < 100);
  endtask

  task automatic t_window();
    int n;
    logic [7:0] q;
    detect(8'h31, 8'h01, 3'b010, 3'b101, 200, n);
    chk("reserved_win", 200, n);
    wr(a_ctl, 8'h00);
    repeat (3) @(posedge clock);
    chk("disabled", 0, active);
    wr(a_dly, 8'h05);
    detect(8'h01, 8'h01, 3'b010, 3'b101, 100, n);
    chk("pwm_off", 100, n);
    pwm_on <= 1'b1;
    wait_irq(100, n);
    chk("delay", 1, n >= 40 && n <= 56);
    pwm_on <= 1'b0;
    repeat (4) @(posedge clock);
    wb(1'b0, a_sts, 8'h00, q);
    chk("edge_fall", 8'h20, q & 8'h38);
  endtask

  task automatic t_low();
    int n;
    detect(8'h21, 8'h01, 3'b010, 3'b101, 50, n);
    chk("low_off", 50, n);
    low_side <= 3'b100;
    wait_irq(100, n);
    chk("low_on", 1, n >= 40 && n <= 56);
    low_side <= 3'h0;
  endtask

  // Short PWM pulses give at most two ticks each, so three hits need counting across pulses.
  task automatic t_recount();
    int n;
    wr(a_ctl, 8'h00);
    wr(a_dly, 8'h00);
    for (int r = 0; r < 2; r++) begin
      detect(8'h03, r ? 8'h01 : 8'h05, 3'b010, 3'b101, 20, n);
      n = 0;
      while (irq !== 1'b1 && n < 120) begin
        pwm_on <= (n % 12) < 6;
        @(posedge clock);
        n++;
      end
      pwm_on <= 1'b0;
      chk("recount", r ? 1 : 0, n < 120);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (ticks == 30000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    {resetn, cyc, stb, we, pwm_on, tstart, tstop, slow} = '0;
    {mismatches, comparisons, ticks} = '0;
    adr = 4'h0;
    wdat = 32'h0;
    wvu = 3'b010;
    expect_wvu = 3'b101;
    low_side = 3'h0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_counts();
    t_change();
    t_pins();
    t_stop();
    t_window();
    t_low();
    t_recount();
    final_report();
  end
endmodule
